// ===== rtl/ibm_pkg.sv
// package for the input bus-master dma engine and its memory-side partner
package bmd_pkg;
    localparam int unsigned ADDR_W       = 32;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned CNT_W        = 24;
    localparam logic [23:0] MAX_BYTES    = 24'h800000;
    localparam logic [1:0]  WORD_BYTES_LOG = 2'h2;
    localparam logic [31:0] WORD_BYTES   = 32'h00000004;
    localparam logic [31:0] NODE_BYTES   = 32'h00000010;
    localparam int unsigned NODE_ALIGN_B = 4;
    localparam int unsigned WORD_ALIGN_B = 2;
    // descriptor node layout, one longword each
    localparam logic [31:0] NODE_OFF_ADDR = 32'h00000000;
    localparam logic [31:0] NODE_OFF_CNT  = 32'h00000004;
    localparam logic [31:0] NODE_OFF_NEXT = 32'h00000008;
    localparam int unsigned NEXT_END_BIT  = 0;
    localparam int unsigned FIFO_DEPTH    = 16;
    localparam int unsigned FIFO_AW       = 4;
    localparam int unsigned MEM_WORDS     = 256;
    localparam int unsigned MEM_AW        = 8;
    localparam logic [1:0]  GRANT_DELAY   = 2'h1;
endpackage

// ===== rtl/ibm_bus_if.sv
// bus-master link between the dma engine and the arbiter/memory end
`timescale 1ns/1ps
interface bmd_bus_if;
    import bmd_pkg::*;
    logic              req;
    logic              gnt;
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              ack;
    logic              retry;
    modport dev  (output req, wr, rd, addr, wdata, input gnt, rdata, ack, retry);
    modport host (input req, wr, rd, addr, wdata, output gnt, rdata, ack, retry);
endinterface

// ===== rtl/ibm_dma_dev.sv
// input bus-master dma engine: fifo, counter, chain walker
// Summary of operation
// (RULE1) start enables bus mastering by the device
// (RULE2) host loads 32-bit destination start address
// (RULE3) length counts bytes, up to 2^23
// (RULE4) every transfer is one full longword
// (RULE5) release bus when fifo empty, re-request
// (RULE6) keep writing until byte count done
// (RULE7) done status pollable; optional interrupt
// (RULE8) chain nodes, 16-byte aligned pointers
// (RULE9) block buffer address is longword aligned
// (RULE10) chain mode: count zero, nodes give lengths
// (RULE11) flush option clears fifo at start
// (RULE12) stop option disables sampling at completion
// (RULE13) status reads 0 done, 1 busy
// (RULE14) sticky overrun on write to full fifo
// (RULE15) abort halts, no further writes
// (RULE16) node: address, count, next, end marker
// (RULE17) request only while mastering and active
`timescale 1ns/1ps
module bmd_dma_dev
    import bmd_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // control
    input  wire logic              start,
    input  wire logic              abort,
    input  wire logic              chain_mode,
    input  wire logic [ADDR_W-1:0] start_addr,
    input  wire logic [CNT_W-1:0]  byte_count,
    input  wire logic              flush_at_start,
    input  wire logic              stop_input_at_completion,
    input  wire logic              irq_enable,
    input  wire logic              overrun_clear,
    // sampled input words
    input  wire logic              sample_valid,
    input  wire logic [DATA_W-1:0] sample_data,
    // status
    output logic                   busy_status,
    output logic                   done_irq,
    output logic                   overrun,
    output logic                   sampling_on,
    output logic                   master_en,
    output logic                   setup_error,
    // bus side
    bmd_bus_if.dev                 bus
);
    typedef enum logic [2:0] {ST_IDLE, ST_NODE_ADDR, ST_NODE_CNT, ST_NODE_NEXT, ST_XFER} bmd_state_e;

    bmd_state_e          state_q, state_d;
    logic [DATA_W-1:0]   fifo_q [FIFO_DEPTH];
    logic [FIFO_AW:0]    wptr_q, rptr_q;
    logic [ADDR_W-1:0]   addr_q, node_q;
    logic [CNT_W-1:0]    left_q;
    logic                last_node_q;
    logic                req_q, wr_q, rd_q;
    logic [ADDR_W-1:0]   baddr_q;
    logic [DATA_W-1:0]   bdata_q;
    logic                busy_q, irq_q, ovr_q, samp_q, mst_q, err_q, stop_q;

    wire fifo_empty = (wptr_q == rptr_q);
    wire fifo_full  = (wptr_q[FIFO_AW-1:0] == rptr_q[FIFO_AW-1:0]) && (wptr_q[FIFO_AW] != rptr_q[FIFO_AW]);
    wire push       = sample_valid && samp_q && !fifo_full;
    wire granted_ok = bus.gnt && bus.ack;
    wire word_done  = wr_q && granted_ok;
    wire read_done  = rd_q && granted_ok;
    wire last_word  = (left_q <= CNT_W'(WORD_BYTES));
    // checks against misaligned buffers and bad counts
    wire align_bad  = chain_mode ? (start_addr[NODE_ALIGN_B-1:0] != '0) // RULE8
                                 : (start_addr[WORD_ALIGN_B-1:0] != '0); // RULE9
    wire count_bad  = chain_mode ? (byte_count != '0) // RULE10
                                 : (byte_count == '0 || byte_count > MAX_BYTES ||
                                    byte_count[WORD_ALIGN_B-1:0] != '0); // RULE3
    wire start_ok   = start && !busy_q && !align_bad && !count_bad;
    wire finishing  = word_done && last_word && (!chain_mode || last_node_q);
    wire overflow   = sample_valid && samp_q && fifo_full;
    wire fetching   = (state_q == ST_NODE_ADDR) || (state_q == ST_NODE_CNT) || (state_q == ST_NODE_NEXT);
    wire want_write = !req_q && mst_q && (state_q == ST_XFER) && !fifo_empty;
    wire want_read  = !req_q && mst_q && fetching;
    wire drop_req   = granted_ok || abort || finishing;

    // wraps at the top of the address space; nothing checks that a buffer stays below it
    function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] d);
        step_addr = ADDR_W'(a + d);
    endfunction

    // node field picked by the fetch step
    wire [ADDR_W-1:0] node_off  = (state_q == ST_NODE_ADDR) ? NODE_OFF_ADDR :
                                  (state_q == ST_NODE_CNT)  ? NODE_OFF_CNT : NODE_OFF_NEXT;
    wire [ADDR_W-1:0] node_addr = step_addr(node_q, node_off);
    wire [ADDR_W-1:0] addr_next = step_addr(addr_q, WORD_BYTES);
    wire [CNT_W-1:0]  left_next = last_word ? '0 : left_q - CNT_W'(WORD_BYTES);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:      if (start_ok) state_d = chain_mode ? ST_NODE_ADDR : ST_XFER;
            ST_NODE_ADDR: if (read_done) state_d = ST_NODE_CNT;
            ST_NODE_CNT:  if (read_done) state_d = ST_NODE_NEXT;
            ST_NODE_NEXT: if (read_done) state_d = ST_XFER;
            ST_XFER:      if (word_done && last_word) state_d = (chain_mode && !last_node_q) ? ST_NODE_ADDR : ST_IDLE; // RULE6
            default:      state_d = ST_IDLE;
        endcase
        if (abort) state_d = ST_IDLE; // RULE15
    end

    always_ff @(posedge clk) begin
        if (push) fifo_q[wptr_q[FIFO_AW-1:0]] <= sample_data;
    end

    // state and fifo pointers; a push in the flush cycle is dropped on purpose
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            wptr_q  <= '0;
            rptr_q  <= '0;
        end else begin
            state_q <= state_d;
            if (start_ok && flush_at_start) begin
                wptr_q <= '0; // RULE11
                rptr_q <= '0;
            end else begin
                if (push) wptr_q <= wptr_q + 1'b1;
                if (word_done) rptr_q <= rptr_q + 1'b1;
            end
        end
    end

    // set wins over clear so an overflow in the clear cycle is never hidden
    always_ff @(posedge clk) begin
        if (rst) begin
            ovr_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            if (overflow) ovr_q <= 1'b1; // RULE14
            else if (overrun_clear) ovr_q <= 1'b0;
            if (start) err_q <= align_bad || count_bad;
        end
    end

    // status flags; abort comes last so it wins over a start for busy and master enable
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            mst_q  <= 1'b0;
            samp_q <= 1'b0;
            irq_q  <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            if (start_ok) begin
                busy_q <= 1'b1; // RULE13
                mst_q  <= 1'b1; // RULE1
                samp_q <= 1'b1;
                irq_q  <= 1'b0;
                stop_q <= stop_input_at_completion;
            end
            if (finishing) begin
                busy_q <= 1'b0; // RULE13
                mst_q  <= 1'b0;
                if (irq_enable) irq_q <= 1'b1; // RULE7
                if (stop_q) samp_q <= 1'b0; // RULE12
            end
            if (abort) begin
                busy_q <= 1'b0; // RULE15
                mst_q  <= 1'b0;
            end
        end
    end

    // transfer address, byte count and chain position
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_q      <= '0;
            node_q      <= '0;
            left_q      <= '0;
            last_node_q <= 1'b0;
        end else begin
            if (start_ok) begin
                addr_q      <= start_addr; // RULE2
                node_q      <= start_addr;
                left_q      <= byte_count;
                last_node_q <= 1'b0;
            end
            if (read_done && state_q == ST_NODE_ADDR) addr_q <= bus.rdata;
            if (read_done && state_q == ST_NODE_CNT) left_q <= bus.rdata[CNT_W-1:0]; // RULE10
            if (read_done && state_q == ST_NODE_NEXT) begin
                last_node_q <= bus.rdata[NEXT_END_BIT]; // RULE16
                node_q      <= {bus.rdata[ADDR_W-1:NODE_ALIGN_B], {NODE_ALIGN_B{1'b0}}}; // RULE8
            end
            if (word_done) begin
                addr_q <= addr_next; // RULE4
                left_q <= left_next; // RULE3
            end
        end
    end

    // one link op at a time; the request drops for a cycle after each answer
    always_ff @(posedge clk) begin
        if (rst) begin
            req_q   <= 1'b0;
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            baddr_q <= '0;
            bdata_q <= '0;
        end else if (drop_req) begin
            req_q <= 1'b0; // RULE17
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
        end else if (want_write) begin
            req_q   <= 1'b1; // RULE5
            wr_q    <= 1'b1;
            baddr_q <= addr_q;
            bdata_q <= fifo_q[rptr_q[FIFO_AW-1:0]]; // RULE4
        end else if (want_read) begin
            req_q   <= 1'b1; // RULE8
            rd_q    <= 1'b1;
            baddr_q <= node_addr;
        end
    end

    assign bus.req   = req_q;
    assign bus.wr    = wr_q;
    assign bus.rd    = rd_q;
    assign bus.addr  = baddr_q;
    assign bus.wdata = bdata_q;
    assign busy_status = busy_q;
    assign done_irq    = irq_q;
    assign overrun     = ovr_q;
    assign sampling_on = samp_q;
    assign master_en   = mst_q;
    assign setup_error = err_q;
endmodule // bmd_dma_dev

// ===== rtl/ibm_mem_host.sv
// arbiter and word memory end of the bus-master link
`timescale 1ns/1ps
module bmd_mem_host
    import bmd_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // user side
    input  wire logic              bus_busy,
    input  wire logic              target_retry,
    input  wire logic              poke_en,
    input  wire logic [MEM_AW-1:0] poke_idx,
    input  wire logic [DATA_W-1:0] poke_data,
    input  wire logic [MEM_AW-1:0] peek_idx,
    output logic [DATA_W-1:0]      peek_data,
    output logic                   write_seen,
    // bus side
    bmd_bus_if.host                bus
);
    logic [DATA_W-1:0] mem_q [MEM_WORDS];
    logic              gnt_q, ack_q, rty_q, seen_q;
    logic [DATA_W-1:0] rdata_q, peek_q;
    // other masters or a busy target hold the device off; it simply waits
    wire               take  = bus.req && gnt_q && !ack_q && !bus_busy && !target_retry;
    wire [MEM_AW-1:0]  widx  = bus.addr[MEM_AW+WORD_ALIGN_B-1:WORD_ALIGN_B];

    always_ff @(posedge clk) begin
        if (take && bus.wr) mem_q[widx] <= bus.wdata;
        else if (poke_en) mem_q[poke_idx] <= poke_data;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gnt_q   <= 1'b0;
            ack_q   <= 1'b0;
            rty_q   <= 1'b0;
            seen_q  <= 1'b0;
            rdata_q <= '0;
            peek_q  <= '0;
        end else begin
            gnt_q   <= bus.req && !bus_busy && !ack_q;
            ack_q   <= take;
            rty_q   <= bus.req && gnt_q && target_retry;
            seen_q  <= take && bus.wr;
            if (take && bus.rd) rdata_q <= mem_q[widx];
            peek_q  <= mem_q[peek_idx];
        end
    end

    assign bus.gnt   = gnt_q;
    assign bus.ack   = ack_q;
    assign bus.retry = rty_q;
    assign bus.rdata = rdata_q;
    assign peek_data = peek_q;
    assign write_seen = seen_q;
endmodule // bmd_mem_host

// ===== test/ibm_dma_checker.sv
// link checker for the dma engine and its memory end
`timescale 1ns/1ps
module bmd_dma_checker
    import bmd_pkg::*;
(
    // clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // link signals
    input wire logic              req,
    input wire logic              gnt,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic              ack,
    input wire logic              retry,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_word_aligned: assert property (req |-> addr[1:0] == 2'h0)
        else $error("unaligned link address");
    chk_one_kind: assert property (req |-> (wr ^ rd))
        else $error("link op not exactly one of read or write");
    // abort may drop a request early, so only a standing one must stay steady
    chk_op_stable: assert property ((req && !ack) |=> !req || ($stable(addr) && $stable(wdata) && $stable(wr)))
        else $error("link op changed before answer");
    chk_gap_after_ack: assert property (ack |=> !req)
        else $error("request not dropped after answer");
    chk_ack_cause: assert property (ack |-> $past(gnt) && $past(req))
        else $error("answer without granted request");
    chk_gnt_cause: assert property (gnt |-> $past(req))
        else $error("grant without request");
    chk_op_bound: assert property ((req && !ack) |-> ##[1:60] (ack || !req))
        else $error("link op left unanswered");
    chk_node_field: assert property (rd |-> addr[3:2] != 2'h3)
        else $error("node read outside its fields");
    // a retried op must not also be accepted in that cycle
    chk_retry_no_ack: assert property (retry |-> !ack)
        else $error("op both retried and accepted");
endmodule // bmd_dma_checker

// ===== test/input_bus_master_dma_tb_top.sv
// bench for the input dma engine facing its memory end
`timescale 1ns/1ps
module input_bus_master_dma_tb_top;
    import bmd_pkg::*;
`define CMP(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
    logic              clk = 0, rst = 1, start = 0, abort = 0, chain_mode = 0, flush_at_start = 0, hold = 0;
    logic              stop_input_at_completion = 0, irq_enable = 1, overrun_clear = 0, sample_valid = 0;
    logic              bus_busy = 0, target_retry = 0, poke_en = 0, busy_status, done_irq, overrun;
    logic              sampling_on, master_en, setup_error, write_seen;
    logic [ADDR_W-1:0] start_addr = 0;
    logic [CNT_W-1:0]  byte_count = 0;
    logic [DATA_W-1:0] sample_data = 0, poke_data = 0, peek_data;
    logic [MEM_AW-1:0] poke_idx = 0, peek_idx = 0;
    logic [DATA_W-1:0] q[$];
    logic [DATA_W-1:0] nd[6] = '{32'h200, 32'h8, 32'h110, 32'h300, 32'h4, 32'h1};
    int                miscompares = 0, n_compared = 0, wcount = 0;
    bmd_bus_if bus_if();
    bmd_dma_dev bmd_dma_dev_inst (.clk(clk), .rst(rst), .start(start), .abort(abort), .chain_mode(chain_mode),
        .start_addr(start_addr), .byte_count(byte_count), .flush_at_start(flush_at_start),
        .stop_input_at_completion(stop_input_at_completion), .irq_enable(irq_enable), .overrun_clear(overrun_clear),
        .sample_valid(sample_valid), .sample_data(sample_data), .busy_status(busy_status), .done_irq(done_irq),
        .overrun(overrun), .sampling_on(sampling_on), .master_en(master_en), .setup_error(setup_error), .bus(bus_if));
    bmd_mem_host bmd_mem_host_inst (.clk(clk), .rst(rst), .bus_busy(bus_busy), .target_retry(target_retry),
        .poke_en(poke_en), .poke_idx(poke_idx), .poke_data(poke_data), .peek_idx(peek_idx), .peek_data(peek_data),
        .write_seen(write_seen), .bus(bus_if));
    bmd_dma_checker bmd_dma_checker_inst (.clk(clk), .rst(rst), .req(bus_if.req), .gnt(bus_if.gnt), .wr(bus_if.wr),
        .rd(bus_if.rd), .ack(bus_if.ack), .retry(bus_if.retry), .addr(bus_if.addr), .wdata(bus_if.wdata));
    always #5 clk = ~clk;
    // random stalls and retries keep the engine re-arbitrating
    always @(posedge clk) begin
        bus_busy <= hold | (($urandom % 4) == 0);
        target_retry <= !hold && (($urandom % 8) == 0);
        if (write_seen === 1'b1) wcount++;
    end
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic go(logic ch, logic [31:0] a, logic [23:0] c, logic fl, logic st, logic exp_busy);
        @(posedge clk);
        {chain_mode, start_addr, byte_count, flush_at_start, stop_input_at_completion, start} <= {ch, a, c, fl, st, 1'b1};
        @(posedge clk) start <= 0;
        @(posedge clk) #1;
        `CMP(busy_status, exp_busy)
        `CMP(master_en, exp_busy)
    endtask
    task automatic push(int n);
        logic [31:0] w;
        repeat (n) begin
            w = $urandom;
            @(posedge clk) {sample_valid, sample_data} <= {1'b1, w};
            q.push_back(w);
        end
        @(posedge clk) sample_valid <= 0;
    endtask
    task automatic wait_done();
        for (int i = 0; i < 3000 && busy_status !== 1'b0; i++) @(posedge clk);
        #1;
        `CMP(busy_status, 1'b0)
    endtask
    task automatic peek(logic [7:0] idx, logic [31:0] exp);
        @(posedge clk) peek_idx <= idx;
        repeat (2) @(posedge clk);
        #1;
        `CMP(peek_data, exp)
    endtask
    initial begin
        void'($urandom(88563));
        repeat (3) @(posedge clk);
        rst <= 0;
        go(0, 32'h40, 24'h20, 0, 0, 1);
        push(8);
        wait_done();
        `CMP(done_irq, 1'b1)
        `CMP(sampling_on, 1'b1)
        for (int i = 0; i < 8; i++) peek(8'h10 + i, q[i]);
        q.delete();
        push(2);
        q.delete();
        for (int i = 0; i < 6; i++) begin
            @(posedge clk) {poke_en, poke_idx, poke_data} <= {1'b1, 8'h40 + 8'((i / 3) * 4 + i % 3), nd[i]};
        end
        @(posedge clk) poke_en <= 0;
        irq_enable <= 0;
        go(1, 32'h100, 24'h0, 1, 1, 1);
        push(3);
        wait_done();
        `CMP(sampling_on, 1'b0)
        `CMP(done_irq, 1'b0)
        `CMP(master_en, 1'b0)
        peek(8'h80, q[0]);
        peek(8'h81, q[1]);
        peek(8'hC0, q[2]);
        go(0, 32'h42, 24'h8, 0, 0, 0);
        `CMP(setup_error, 1'b1)
        go(1, 32'h108, 24'h0, 0, 0, 0);
        `CMP(setup_error, 1'b1)
        go(1, 32'h100, 24'h4, 0, 0, 0);
        `CMP(setup_error, 1'b1)
        go(0, 32'h40, 24'h800004, 0, 0, 0);
        `CMP(setup_error, 1'b1)
        hold = 1;
        go(0, 32'h0, 24'h80, 1, 0, 1);
        `CMP(setup_error, 1'b0)
        push(FIFO_DEPTH + 2);
        `CMP(overrun, 1'b1)
        @(posedge clk) abort <= 1;
        @(posedge clk) abort <= 0;
        hold <= 0;
        wcount = 0;
        repeat (30) @(posedge clk);
        `CMP(wcount, 0)
        `CMP(busy_status, 1'b0)
        `CMP(master_en, 1'b0)
        @(posedge clk) overrun_clear <= 1;
        @(posedge clk) overrun_clear <= 0;
        @(posedge clk) #1;
        `CMP(overrun, 1'b0)
        final_report();
    end
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
endmodule // input_bus_master_dma_tb_top
